//--- pkg/cftr_pkg.sv
package cftr_pkg;
   // ------------------------------------------------------------
   // Register offsets and reset values
   // ------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFS_CRC_SEED_LOW = 6'h23;
   localparam logic [5:0] OFS_CRC_SEED_HIGH = 6'h24;
   localparam logic [5:0] OFS_RESERVED_A = 6'h25;
   localparam logic [5:0] OFS_TEST_PIN_SRC = 6'h26;
   localparam logic [5:0] OFS_RESERVED_B = 6'h27;
   localparam logic [5:0] OFS_FIFO_WARN = 6'h29;
   localparam logic [5:0] OFS_TIMER_TICK = 6'h2A;
   localparam logic [7:0] RST_CRC_SEED_LOW = 8'h63;
   localparam logic [7:0] RST_CRC_SEED_HIGH = 8'h63;
   localparam logic [7:0] RST_RESERVED_A = 8'h00;
   localparam logic [7:0] RST_TEST_PIN_SRC = 8'h00;
   localparam logic [7:0] RST_FIFO_WARN = 8'h08;
   localparam logic [7:0] RST_TIMER_TICK = 8'h07;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int SRC_LSB = 0;
   localparam int SRC_W = 3;
   localparam int WARN_LSB = 0;
   localparam int WARN_W = 6;
   localparam int EXP_LSB = 0;
   localparam int EXP_W = 5;
   localparam int PERIODIC_BIT = 5;
   // ------------------------------------------------------------
   // Sizes and counts
   // ------------------------------------------------------------
   localparam int FIFO_DEPTH = 64;
   localparam int CNT_W = 7;
   localparam logic [4:0] MAX_DIV_EXP = 5'h15;
   localparam int DIV_W = 21;
   localparam int CLK_FREQ_HZ = 25000000;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SRC_LOW = 3'h0,
      SRC_HIGH = 3'h1,
      SRC_MILLER = 3'h2,
      SRC_SERIAL = 3'h3,
      SRC_CARRIER = 3'h4,
      SRC_SUBCARRIER = 3'h5
   } cftr_src_e;
   typedef enum logic [0:0] {
      TMR_IDLE = 1'h0,
      TMR_RUN = 1'h1
   } cftr_tmr_e;
   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wrData;
      logic wrEn;
      logic rdEn;
   } cftr_bus_s;
   typedef struct packed {
      logic load;
      logic [15:0] value;
   } cftr_seed_s;
endpackage

//--- core/cftr_regs.sv
// Summary of operation
// - Low seed byte loads into CRC on transmit, receive and compute start.
// - High seed byte loads into upper CRC half on the same events.
// - In short CRC mode the high seed byte is ignored.
// - Test pin source 0..3 gives low, high, Miller envelope, raw data.
// - Codes 4 and 5 give carrier and subcarrier demodulator; 6, 7 reserved.
// - Nearly-full flag set while free space is at or below threshold.
// - Nearly-empty flag set while byte count is at or below threshold.
// - Periodic mode reloads the preset at end of count and keeps going.
// - One-shot mode stops at zero and raises the expired event.
// - Tick rate is device clock over two to the divider exponent, 0..21.
// - Short select picks an 8-bit CRC, else a 16-bit CRC.
// - Preset loads at start and on periodic reload; zero preset blocks a start.
`timescale 1ns/10ps
`default_nettype none
module cftr_regs (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Host register port
   input wire cftr_pkg::cftr_bus_s hostBus,
   output logic [7:0] regRdData,
   // CRC seeding events and mode
   input wire logic txStart,
   input wire logic rxStart,
   input wire logic crcComputeCmd,
   input wire logic crcEnable,
   input wire logic crcShortSelect,
   output cftr_pkg::cftr_seed_s crcSeed,
   // Test pin sources
   input wire logic millerEnvelope,
   input wire logic serialTxData,
   input wire logic carrierDemod,
   input wire logic subcarrierDemod,
   output logic multiFunctionPin,
   // FIFO level
   input wire logic [cftr_pkg::CNT_W-1:0] fifoCount,
   output logic fifoNearlyFullFlag,
   output logic fifoNearlyEmptyFlag,
   // Timer
   input wire logic [7:0] timerPreset,
   input wire logic timerStart,
   input wire logic timerStop,
   output logic [7:0] timerValue,
   output logic timerRunning,
   output logic timerExpiredFlag
);
   import cftr_pkg::*;

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [7:0] seedLow_q, seedLow_d;
   logic [7:0] seedHigh_q, seedHigh_d;
   logic [7:0] rsvdA_q, rsvdA_d;
   logic [7:0] srcSel_q, srcSel_d;
   logic [7:0] warn_q, warn_d;
   logic [7:0] tick_q, tick_d;
   logic [7:0] rdData_q, rdData_d;

   // Writes land next edge; reads registered, unmapped and write-only give zero
   always_comb begin
      seedLow_d = seedLow_q;
      seedHigh_d = seedHigh_q;
      rsvdA_d = rsvdA_q;
      srcSel_d = srcSel_q;
      warn_d = warn_q;
      tick_d = tick_q;
      rdData_d = rdData_q;
      if (hostBus.wrEn) begin
         case (hostBus.addr)
            OFS_CRC_SEED_LOW: seedLow_d = hostBus.wrData;
            OFS_CRC_SEED_HIGH: seedHigh_d = hostBus.wrData;
            OFS_RESERVED_A: rsvdA_d = hostBus.wrData; // Kept as written
            OFS_TEST_PIN_SRC: srcSel_d = hostBus.wrData;
            OFS_FIFO_WARN: warn_d = hostBus.wrData;
            OFS_TIMER_TICK: tick_d = hostBus.wrData;
            default: ;
         endcase
      end
      if (hostBus.rdEn) begin
         case (hostBus.addr)
            OFS_CRC_SEED_LOW: rdData_d = seedLow_q;
            OFS_CRC_SEED_HIGH: rdData_d = seedHigh_q;
            OFS_RESERVED_A: rdData_d = rsvdA_q;
            OFS_TEST_PIN_SRC: rdData_d = srcSel_q;
            OFS_FIFO_WARN: rdData_d = warn_q;
            OFS_TIMER_TICK: rdData_d = tick_q;
            default: rdData_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         seedLow_q <= RST_CRC_SEED_LOW;
         seedHigh_q <= RST_CRC_SEED_HIGH;
         rsvdA_q <= RST_RESERVED_A;
         srcSel_q <= RST_TEST_PIN_SRC;
         warn_q <= RST_FIFO_WARN;
         tick_q <= RST_TIMER_TICK;
         rdData_q <= 8'h00;
      end else begin
         seedLow_q <= seedLow_d;
         seedHigh_q <= seedHigh_d;
         rsvdA_q <= rsvdA_d;
         srcSel_q <= srcSel_d;
         warn_q <= warn_d;
         tick_q <= tick_d;
         rdData_q <= rdData_d;
      end
   end

   assign regRdData = rdData_q;

   // ------------------------------------------------------------
   // CRC seed
   // ------------------------------------------------------------
   cftr_seed_s seed_q, seed_d;
   logic seedEvent;

   assign seedEvent = crcEnable && (txStart || rxStart || crcComputeCmd);

   // Seed value held between loads so the CRC unit may sample it late
   always_comb begin
      seed_d = seed_q;
      seed_d.load = 1'b0;
      if (seedEvent) begin
         seed_d.load = 1'b1;
         seed_d.value[7:0] = seedLow_q;
         // Short CRC uses only the low byte
         seed_d.value[15:8] = crcShortSelect ? 8'h00 : seedHigh_q;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         seed_q <= '0;
      end else begin
         seed_q <= seed_d;
      end
   end

   assign crcSeed = seed_q;

   // ------------------------------------------------------------
   // Test pin selector
   // ------------------------------------------------------------
   logic mfPin_q, mfPin_d;

   // Reserved codes park the pin low rather than leak an internal node
   always_comb begin
      case (cftr_src_e'(srcSel_q[SRC_LSB +: SRC_W]))
         SRC_LOW: mfPin_d = 1'b0;
         SRC_HIGH: mfPin_d = 1'b1;
         SRC_MILLER: mfPin_d = millerEnvelope;
         SRC_SERIAL: mfPin_d = serialTxData;
         SRC_CARRIER: mfPin_d = carrierDemod;
         SRC_SUBCARRIER: mfPin_d = subcarrierDemod;
         default: mfPin_d = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mfPin_q <= 1'b0;
      end else begin
         mfPin_q <= mfPin_d;
      end
   end

   assign multiFunctionPin = mfPin_q;

   // ------------------------------------------------------------
   // FIFO warning flags
   // ------------------------------------------------------------
   logic [CNT_W-1:0] freeSpace;
   logic [CNT_W-1:0] thresh;
   logic nearFull_q, nearFull_d;
   logic nearEmpty_q, nearEmpty_d;

   assign freeSpace = CNT_W'(FIFO_DEPTH) - fifoCount;
   assign thresh = {1'b0, warn_q[WARN_LSB +: WARN_W]};

   // Flags follow the level one cycle late, no hysteresis
   always_comb begin
      nearFull_d = (freeSpace <= thresh);
      nearEmpty_d = (fifoCount <= thresh);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         nearFull_q <= 1'b0;
         nearEmpty_q <= 1'b1;
      end else begin
         nearFull_q <= nearFull_d;
         nearEmpty_q <= nearEmpty_d;
      end
   end

   assign fifoNearlyFullFlag = nearFull_q;
   assign fifoNearlyEmptyFlag = nearEmpty_q;

   // ------------------------------------------------------------
   // Timer prescaler and counter
   // ------------------------------------------------------------
   logic [DIV_W-1:0] div_q, div_d;
   logic [DIV_W-1:0] divMask;
   logic [4:0] divExp;
   logic tickEn;
   cftr_tmr_e tState_q, tState_d;
   logic [7:0] tCnt_q, tCnt_d;
   logic tExp_q, tExp_d;
   logic periodic;

   // Exponents above the legal top are clamped
   assign divExp = (tick_q[EXP_LSB +: EXP_W] > MAX_DIV_EXP) ?
                   MAX_DIV_EXP : tick_q[EXP_LSB +: EXP_W];
   assign divMask = (DIV_W'(1) << divExp) - DIV_W'(1);
   // One-cycle enable every 2^exp clocks; a derived clock would split domains
   assign tickEn = ((div_q & divMask) == divMask);
   assign periodic = tick_q[PERIODIC_BIT];

   always_comb begin
      div_d = div_q + DIV_W'(1);
      tState_d = tState_q;
      tCnt_d = tCnt_q;
      tExp_d = 1'b0;
      if (timerStart && (timerPreset != 8'h00)) begin
         tState_d = TMR_RUN;
         tCnt_d = timerPreset;
      end else if (timerStop) begin
         tState_d = TMR_IDLE;
      end else begin
         case (tState_q)
            TMR_RUN: begin
               if (tickEn) begin
                  if (tCnt_q <= 8'h01 && periodic) begin
                     tCnt_d = timerPreset;
                  end else if (tCnt_q <= 8'h01) begin
                     tCnt_d = 8'h00;
                     tState_d = TMR_IDLE;
                     tExp_d = 1'b1;
                  end else begin
                     tCnt_d = tCnt_q - 8'h01;
                  end
               end
            end
            TMR_IDLE: ;
            default: tState_d = TMR_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= '0;
         tState_q <= TMR_IDLE;
         tCnt_q <= 8'h00;
         tExp_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tState_q <= tState_d;
         tCnt_q <= tCnt_d;
         tExp_q <= tExp_d;
      end
   end

   assign timerValue = tCnt_q;
   assign timerRunning = (tState_q == TMR_RUN);
   assign timerExpiredFlag = tExp_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence lastTick;
      tState_q == TMR_RUN && tickEn && tCnt_q == 8'h01 && !timerStart && !timerStop;
   endsequence

   seed_low_load_a: assert property (seedEvent |=> crcSeed.load &&
      crcSeed.value[7:0] == $past(seedLow_q)) else $error("low seed not loaded");
   seed_high_load_a: assert property (seedEvent && !crcShortSelect |=>
      crcSeed.value[15:8] == $past(seedHigh_q)) else $error("high seed not loaded");
   seed_short_a: assert property (seedEvent && crcShortSelect |=>
      crcSeed.value[15:8] == 8'h00) else $error("high seed used in short mode");
   seed_idle_a: assert property (!crcEnable |=> !crcSeed.load)
      else $error("seed load with CRC disabled");
   pin_const_a: assert property (srcSel_q[2:0] == 3'h1 && $stable(srcSel_q)
      |=> multiFunctionPin) else $error("pin not high");
   pin_demod_a: assert property (srcSel_q[2:0] == 3'h4 |=>
      multiFunctionPin == $past(carrierDemod)) else $error("pin not carrier");
   near_full_a: assert property (##1 fifoNearlyFullFlag ==
      ($past(freeSpace) <= $past(thresh))) else $error("nearly full wrong");
   near_empty_a: assert property (##1 fifoNearlyEmptyFlag ==
      ($past(fifoCount) <= $past(thresh))) else $error("nearly empty wrong");
   tick_rate_a: assert property (divExp == 5'h02 && tickEn &&
      $stable(divExp) |=> !tickEn [*3] ##1 tickEn) else $error("tick rate wrong");
   periodic_reload_a: assert property (lastTick and periodic |=>
      timerRunning && timerValue == $past(timerPreset) && !timerExpiredFlag)
      else $error("periodic reload failed");
   oneshot_stop_a: assert property (lastTick and !periodic |=>
      timerExpiredFlag && !timerRunning && timerValue == 8'h00
      ##1 !timerExpiredFlag && (!timerRunning || $past(timerStart)))
      else $error("one-shot end wrong");
   zero_preset_a: assert property (timerStart && timerPreset == 8'h00 &&
      !timerRunning |=> !timerRunning) else $error("zero preset started");
endmodule
`default_nettype wire

//--- test/cftr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cftr_host_model (
   // Clock
   input wire logic ref_clk,
   // Register port toward the device
   output var cftr_pkg::cftr_bus_s hostBus
);
   import cftr_pkg::*;
   // Idle bus shows no enables and junk address and data
   initial hostBus = '{addr: 6'h3F, wrData: 8'hFF, wrEn: 1'b0, rdEn: 1'b0};
   // One access per cycle, launched at the falling edge and held to the next one
   task automatic access(input logic [5:0] a, input logic [7:0] d, input logic we,
                         input logic re);
      logic [7:0] v;
      v = d;
      if (we && a == OFS_RESERVED_A) v = 8'h00; // Reserved byte kept zero
      if (we && a == OFS_TIMER_TICK && v[4:0] > MAX_DIV_EXP) v[4:0] = MAX_DIV_EXP;
      hostBus = '{addr: a, wrData: v, wrEn: we, rdEn: re};
      @(negedge ref_clk);
   endtask
   // Released lines flip so a stale value never looks valid; held for one cycle
   task automatic idle();
      hostBus = '{addr: ~hostBus.addr, wrData: ~hostBus.wrData, wrEn: 1'b0, rdEn: 1'b0};
      @(negedge ref_clk);
   endtask
endmodule
`default_nettype wire

//--- test/crc_fifo_timer_config_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CFTR_CHK(got, exp) begin \
   compares++; \
   if ((got) !== (exp)) begin \
      nMismatch++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module crc_fifo_timer_config_regs_tb_top;
   import cftr_pkg::*;
   typedef struct {int sel; logic [16:0] val;} cftr_note_s;
   // --------------------------------------------------------------
   // Signals and tables
   // --------------------------------------------------------------
   logic ref_clk, rst_n, txStart, rxStart, crcComputeCmd, crcEnable, crcShortSelect, pe;
   logic millerEnvelope, serialTxData, carrierDemod, subcarrierDemod, timerStart, timerStop;
   logic multiFunctionPin, fifoNearlyFullFlag, fifoNearlyEmptyFlag, timerRunning;
   logic timerExpiredFlag;
   logic [CNT_W-1:0] fifoCount;
   logic [7:0] timerPreset, regRdData, timerValue, lo, hi, d;
   logic [3:0] ins;
   logic [15:0] lastSeed;
   logic [31:0] lfsr = 32'hBB500322;
   cftr_bus_s hostBus;
   cftr_seed_s crcSeed;
   cftr_note_s q[$];
   int nMismatch = 0;
   int compares = 0;
   localparam logic [5:0] RA [8] = '{OFS_CRC_SEED_LOW, OFS_CRC_SEED_HIGH, OFS_RESERVED_A,
      OFS_TEST_PIN_SRC, OFS_RESERVED_B, OFS_FIFO_WARN, OFS_TIMER_TICK, 6'h3F};
   localparam logic [7:0] RV [8] = '{RST_CRC_SEED_LOW, RST_CRC_SEED_HIGH, RST_RESERVED_A,
      RST_TEST_PIN_SRC, 8'h00, RST_FIFO_WARN, RST_TIMER_TICK, 8'h00};
   // Bits checked for each register; zero marks a place that reads back 00
   localparam logic [7:0] EM [8] = '{8'hFF, 8'hFF, 8'h00, 8'h07, 8'h00, 8'h3F, 8'h3F, 8'h00};
   cftr_host_model u_host (.ref_clk(ref_clk), .hostBus(hostBus));
   cftr_regs u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hostBus(hostBus),
      .regRdData(regRdData), .txStart(txStart), .rxStart(rxStart),
      .crcComputeCmd(crcComputeCmd), .crcEnable(crcEnable), .crcShortSelect(crcShortSelect),
      .crcSeed(crcSeed), .millerEnvelope(millerEnvelope), .serialTxData(serialTxData),
      .carrierDemod(carrierDemod), .subcarrierDemod(subcarrierDemod),
      .multiFunctionPin(multiFunctionPin), .fifoCount(fifoCount),
      .fifoNearlyFullFlag(fifoNearlyFullFlag), .fifoNearlyEmptyFlag(fifoNearlyEmptyFlag),
      .timerPreset(timerPreset), .timerStart(timerStart), .timerStop(timerStop),
      .timerValue(timerValue), .timerRunning(timerRunning),
      .timerExpiredFlag(timerExpiredFlag));
   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   function automatic logic [7:0] rnd();
      lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'h80200003 : lfsr >> 1;
      return lfsr[7:0];
   endfunction
   function automatic logic [16:0] obs(input int s);
      case (s)
         0: return {9'h000, regRdData};
         1: return crcSeed;
         2: return {16'h0000, multiFunctionPin};
         3: return {15'h0000, fifoNearlyFullFlag, fifoNearlyEmptyFlag};
         default: return {7'h00, timerRunning, timerExpiredFlag, timerValue};
      endcase
   endfunction
   task automatic note(input int s, input logic [16:0] v);
      q.push_back('{s, v});
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      u_host.access(a, v, 1'b1, 1'b0);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      u_host.access(a, 8'h00, 1'b0, 1'b1);
      note(0, {9'h000, e});
   endtask
   task automatic rdAll();
      for (int i = 0; i < 8; i++) rd(RA[i], RV[i]);
      u_host.idle();
   endtask
   // Timer step: optional start, then the state expected one edge later
   task automatic tmr(input logic st, input logic [16:0] e);
      timerStart = st;
      @(negedge ref_clk);
      note(4, e);
   endtask
   task automatic tallyAndFinish();
      $display("Compares %0d, mismatches %0d", compares, nMismatch);
      if (nMismatch == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // --------------------------------------------------------------
   // Clock, checker and watchdog
   // --------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Results are settled just after the falling edge, so notes are taken there
   initial forever begin
      @(negedge ref_clk);
      #1;
      while (q.size() > 0) begin
         `CFTR_CHK(obs(q[0].sel), q[0].val)
         void'(q.pop_front());
      end
   end
   // About 180 cycles are expected; over fifteen times that means a hang
   initial begin
      repeat (3000) @(posedge ref_clk);
      nMismatch++;
      tallyAndFinish();
   end
   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      {txStart, rxStart, crcComputeCmd, crcEnable, crcShortSelect, timerStart, timerStop} = 7'h00;
      {millerEnvelope, serialTxData, carrierDemod, subcarrierDemod} = 4'h0;
      fifoCount = 7'h00;
      timerPreset = 8'h00;
      lastSeed = 16'h0000;
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      rdAll();
      for (int i = 0; i < 8; i++) begin
         d = (EM[i] == 8'h00) ? rnd() : rnd() & EM[i];
         // Host never programs an exponent above the legal top
         if (RA[i] == OFS_TIMER_TICK && d[4:0] > MAX_DIV_EXP) d[4:0] = MAX_DIV_EXP;
         wr(RA[i], d);
         rd(RA[i], d & EM[i]);
      end
      u_host.idle();
      rst_n = 1'b0;
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      rdAll();
      $display("Test registers done");
      for (int s = 0; s < 8; s++) begin
         wr(OFS_TEST_PIN_SRC, 8'(s));
         u_host.idle();
         repeat (3) begin
            ins = 4'(rnd());
            {millerEnvelope, serialTxData, carrierDemod, subcarrierDemod} = ins;
            pe = (s == 1) || (s >= 2 && s <= 5 && ins[5 - s]);
            @(negedge ref_clk);
            note(2, {16'h0000, pe});
         end
      end
      $display("Test pin done");
      lo = rnd();
      hi = rnd();
      wr(OFS_CRC_SEED_LOW, lo);
      wr(OFS_CRC_SEED_HIGH, hi);
      u_host.idle();
      for (int k = 0; k < 9; k++) begin
         {txStart, rxStart, crcComputeCmd} = 3'b100 >> (k % 3);
         crcEnable = (k != 4);
         crcShortSelect = k[0];
         @(negedge ref_clk);
         if (crcEnable) lastSeed = {crcShortSelect ? 8'h00 : hi, lo};
         note(1, {crcEnable, lastSeed});
      end
      {txStart, rxStart, crcComputeCmd} = 3'b000;
      $display("Test crc seed done");
      for (int i = 0; i < 10; i++) begin
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'h3F : rnd() & 8'h3F;
         wr(OFS_FIFO_WARN, d);
         u_host.idle();
         for (int j = 0; j < 4; j++) begin
            fifoCount = (j == 0) ? 7'(d) : (j == 1) ? 7'(d) + 7'h01 :
                        (j == 2) ? 7'h40 - 7'(d) : 7'h3F - 7'(d);
            @(negedge ref_clk);
            note(3, {15'h0000, (7'h40 - fifoCount <= 7'(d)), (fifoCount <= 7'(d))});
         end
      end
      $display("Test fifo flags done");
      wr(OFS_TIMER_TICK, 8'h00);
      u_host.idle();
      tmr(1'b1, 17'h00000);
      timerPreset = 8'h02;
      tmr(1'b1, 17'h00202);
      timerPreset = 8'h09;
      tmr(1'b0, 17'h00201);
      tmr(1'b0, 17'h00100);
      tmr(1'b0, 17'h00000);
      wr(OFS_TIMER_TICK, 8'h20);
      u_host.idle();
      timerPreset = 8'h02;
      tmr(1'b1, 17'h00202);
      tmr(1'b0, 17'h00201);
      tmr(1'b0, 17'h00202);
      timerPreset = 8'h05;
      tmr(1'b1, 17'h00205);
      timerStop = 1'b1;
      tmr(1'b0, 17'h00005);
      timerStop = 1'b0;
      wr(OFS_TIMER_TICK, 8'h02);
      u_host.idle();
      timerPreset = 8'h03;
      tmr(1'b1, 17'h00203);
      timerStart = 1'b0;
      for (int i = 0; i < 20 && timerValue !== 8'h02; i++) @(negedge ref_clk);
      repeat (3) tmr(1'b0, 17'h00202);
      tmr(1'b0, 17'h00201);
      $display("Test timer done");
      #5;
      tallyAndFinish();
   end
endmodule
`default_nettype wire
